// file: sart_pkg.sv
// constants for the split auto-reload timer: sfr offsets, control fields, dividers
// assumes an 8-bit special function register bus driven by the processor core

package sart_pkg;
  localparam logic [7:0] ADDR_CONTROL     = 8'hc8;
  localparam logic [7:0] ADDR_RELOAD_LOW  = 8'hca;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb;
  localparam logic [7:0] ADDR_COUNT_LOW   = 8'hcc;
  localparam logic [7:0] ADDR_COUNT_HIGH  = 8'hcd;
  localparam int BIT_HIGH_FLAG   = 7;
  localparam int BIT_LOW_FLAG    = 6;
  localparam int BIT_LOW_IRQ_EN  = 5;
  localparam int BIT_CAPTURE_EN  = 4;
  localparam int BIT_SPLIT       = 3;
  localparam int BIT_RUN         = 2;
  localparam int BIT_ALT_CLOCK   = 0;
  localparam logic [7:0] CONTROL_WRITE_MASK = 8'hfd;
  localparam logic [7:0] RESET_BYTE         = 8'h00;
  localparam logic [7:0] BYTE_MAX           = 8'hff;
  localparam int CORE_DIV         = 12;
  localparam int EXT_DIV          = 8;
  localparam logic [3:0] CORE_DIV_LAST = 4'(CORE_DIV - 1);
  localparam logic [2:0] EXT_DIV_LAST  = 3'(EXT_DIV - 1);
endpackage

// file: sart_timer.sv
// split auto-reload timer: 16-bit or dual 8-bit counters with capture and interrupt
// assumes sfr bus signals are synchronous to CORE_CLK_I; external and lfo clock inputs pass through synchronisers
`timescale 1ns/1ps
module sart_timer
  import sart_pkg::*;
(
  // clock and reset
  input  wire logic       CORE_CLK_I,
  input  wire logic       RESET_N_I,
  // special function register bus
  input  wire logic [7:0] SFR_ADDR_I,
  input  wire logic [7:0] SFR_WDATA_I,
  input  wire logic       SFR_WR_I,
  output logic      [7:0] SFR_RDATA_O,
  // clock sources and shared clock control bits
  input  wire logic       EXT_CLK_I,
  input  wire logic       LFO_CLK_I,
  input  wire logic       LOW_BYTE_CORE_CLOCK_SELECT_I,
  input  wire logic       HIGH_BYTE_CORE_CLOCK_SELECT_I,
  // interrupt
  input  wire logic       GLOBAL_TIMER_IRQ_ENABLE_I,
  output logic            IRQ_O
);

  // register state
  logic [7:0] timer_control;
  logic [7:0] reload_byte [2];
  logic [7:0] count_byte  [2];

  // prescalers and synchronisers
  logic [3:0] core_div_cnt;
  logic [2:0] ext_div_cnt;
  logic [1:0] ext_sync;
  logic       ext_prev;
  logic [1:0] lfo_sync;
  logic       lfo_prev;

  // per-byte wiring: index 0 is the low byte, index 1 the high byte
  logic [1:0] byte_core_sel;
  logic [1:0] byte_tick;
  logic [1:0] byte_run;
  logic [1:0] byte_en;
  logic [1:0] byte_at_max;
  logic [1:0] byte_wrap;
  logic [1:0] byte_reload;
  logic [1:0] wr_reload;
  logic [1:0] wr_count;
  logic [1:0] reload_load;
  logic [7:0] next_count  [2];
  logic [7:0] next_reload [2];

  // control fields
  wire split_mode_select  = timer_control[BIT_SPLIT];
  wire run_enable         = timer_control[BIT_RUN];
  wire low_irq_enable     = timer_control[BIT_LOW_IRQ_EN];
  wire lfo_capture_enable = timer_control[BIT_CAPTURE_EN];
  wire alt_clock_select   = timer_control[BIT_ALT_CLOCK];
  wire high_overflow_flag = timer_control[BIT_HIGH_FLAG];
  wire low_overflow_flag  = timer_control[BIT_LOW_FLAG];

  // bus decode
  wire wr_control     = SFR_WR_I && (SFR_ADDR_I == ADDR_CONTROL);
  assign wr_reload[0] = SFR_WR_I && (SFR_ADDR_I == ADDR_RELOAD_LOW);
  assign wr_reload[1] = SFR_WR_I && (SFR_ADDR_I == ADDR_RELOAD_HIGH);
  assign wr_count[0]  = SFR_WR_I && (SFR_ADDR_I == ADDR_COUNT_LOW);
  assign wr_count[1]  = SFR_WR_I && (SFR_ADDR_I == ADDR_COUNT_HIGH);

  // core clock divided by 12, free running
  wire core_tick = (core_div_cnt == CORE_DIV_LAST);

  // external clock divided by 8: counts synchronised rising edges of the pin
  wire ext_rise = ext_sync[1] && !ext_prev;
  wire ext_tick = ext_rise && (ext_div_cnt == EXT_DIV_LAST);
  wire alt_tick = alt_clock_select ? ext_tick : core_tick;

  // per-byte clock choice and run gating
  assign byte_core_sel[0] = LOW_BYTE_CORE_CLOCK_SELECT_I;
  assign byte_core_sel[1] = split_mode_select ? HIGH_BYTE_CORE_CLOCK_SELECT_I
                                              : LOW_BYTE_CORE_CLOCK_SELECT_I;
  assign byte_run[0]      = split_mode_select || run_enable;
  assign byte_run[1]      = run_enable;
  assign byte_en[0]       = byte_tick[0] && byte_run[0];
  assign byte_en[1]       = split_mode_select ? (byte_tick[1] && byte_run[1])
                                              : byte_wrap[0];

  // in 16-bit mode a low wrap alone rolls to zero; only the full wrap reloads
  wire full_wrap = !split_mode_select && byte_wrap[1];
  assign byte_reload[0] = split_mode_select ? byte_wrap[0] : full_wrap;
  assign byte_reload[1] = byte_wrap[1];

  // lfo falling edge after synchroniser
  wire lfo_fall = lfo_prev && !lfo_sync[1];
  wire capture  = lfo_capture_enable && GLOBAL_TIMER_IRQ_ENABLE_I && lfo_fall;

  // control next value: a hardware set wins over a same-cycle software clear
  wire [7:0] sw_control = (SFR_WDATA_I & CONTROL_WRITE_MASK);
  wire next_high_flag = (wr_control ? sw_control[BIT_HIGH_FLAG] : high_overflow_flag)
                        | byte_wrap[1];
  wire next_low_flag  = (wr_control ? sw_control[BIT_LOW_FLAG] : low_overflow_flag)
                        | byte_wrap[0];
  wire [7:0] next_control = {next_high_flag, next_low_flag,
                             wr_control ? sw_control[5:0] : timer_control[5:0]};

  // interrupt: flags stay sticky, so request follows them
  wire irq_low_part = low_irq_enable && low_overflow_flag;
  wire next_irq = GLOBAL_TIMER_IRQ_ENABLE_I
                  && (high_overflow_flag || irq_low_part || capture);

  // read mux
  assign SFR_RDATA_O = (SFR_ADDR_I == ADDR_CONTROL)     ? timer_control :
                       (SFR_ADDR_I == ADDR_RELOAD_LOW)  ? reload_byte[0] :
                       (SFR_ADDR_I == ADDR_RELOAD_HIGH) ? reload_byte[1] :
                       (SFR_ADDR_I == ADDR_COUNT_LOW)   ? count_byte[0] :
                       (SFR_ADDR_I == ADDR_COUNT_HIGH)  ? count_byte[1] :
                                                          8'h00;

  // core divider
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      core_div_cnt <= 4'h0;
    end
    else
    begin
      core_div_cnt <= core_tick ? 4'h0 : 4'(core_div_cnt + 4'h1);
    end
  end

  // external clock synchroniser
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      ext_sync <= 2'h0;
    end
    else
    begin
      ext_sync <= {ext_sync[0], EXT_CLK_I};
    end
  end

  // previous synchronised level, for the edge detect
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      ext_prev <= 1'b0;
    end
    else
    begin
      ext_prev <= ext_sync[1];
    end
  end

  // external edge counter, wraps every 8 edges
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      ext_div_cnt <= 3'h0;
    end
    else if (ext_rise)
    begin
      ext_div_cnt <= 3'(ext_div_cnt + 3'h1);
    end
  end

  // lfo synchroniser
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      lfo_sync <= 2'h0;
    end
    else
    begin
      lfo_sync <= {lfo_sync[0], LFO_CLK_I};
    end
  end

  // low after reset, so a high lfo pin gives no false falling edge
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      lfo_prev <= 1'b0;
    end
    else
    begin
      lfo_prev <= lfo_sync[1];
    end
  end

  // control register
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      timer_control <= RESET_BYTE;
    end
    else
    begin
      timer_control <= next_control;
    end
  end

  // interrupt request
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      IRQ_O <= 1'b0;
    end
    else
    begin
      IRQ_O <= next_irq;
    end
  end

  // per-byte counter and reload
  generate
    for (genvar b = 0; b < 2; b++)
    begin : g_byte
      assign byte_tick[b]   = byte_core_sel[b] ? 1'b1 : alt_tick;
      assign byte_at_max[b] = (count_byte[b] == BYTE_MAX);
      assign byte_wrap[b]   = byte_en[b] && byte_at_max[b];
      assign next_count[b]  = byte_reload[b] ? reload_byte[b]
                                             : 8'(count_byte[b] + 8'h01);
      // capture beats a software reload write in the same cycle
      assign reload_load[b] = capture || wr_reload[b];
      assign next_reload[b] = capture ? count_byte[b] : SFR_WDATA_I;

      always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
      begin
        if (!RESET_N_I)
        begin
          count_byte[b] <= RESET_BYTE;
        end
        else if (wr_count[b])
        begin
          count_byte[b] <= SFR_WDATA_I;
        end
        else if (byte_en[b])
        begin
          count_byte[b] <= next_count[b];
        end
      end

      always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
      begin
        if (!RESET_N_I)
        begin
          reload_byte[b] <= RESET_BYTE;
        end
        else if (reload_load[b])
        begin
          reload_byte[b] <= next_reload[b];
        end
      end
    end
  endgenerate

endmodule // sart_timer

// file: sart_asserts.sv
// checker on the timer register port and interrupt line
// assumes it is bound to sart_timer and sees only its ports
`timescale 1ns/1ps
module sart_asserts
  import sart_pkg::*;
(
  // watched ports
  input wire logic       CORE_CLK_I,
  input wire logic       RESET_N_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic [7:0] SFR_WDATA_I,
  input wire logic       SFR_WR_I,
  input wire logic [7:0] SFR_RDATA_O,
  input wire logic       GLOBAL_TIMER_IRQ_ENABLE_I,
  input wire logic       IRQ_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  wire is_ctl = SFR_ADDR_I == ADDR_CONTROL;
  wire is_rel = SFR_ADDR_I inside {ADDR_RELOAD_LOW, ADDR_RELOAD_HIGH};
  wire mapped = is_ctl || (SFR_ADDR_I inside {[ADDR_RELOAD_LOW:ADDR_COUNT_HIGH]});
  wire en_flag = SFR_RDATA_O[7] || (SFR_RDATA_O[6] && SFR_RDATA_O[5]);
  // write taken, address then held one cycle
  sequence s_held_write(logic hit);
    SFR_WR_I && hit ##1 $stable(SFR_ADDR_I);
  endsequence
  unused_bit_a: assert property (is_ctl |-> !SFR_RDATA_O[1])
    else $error("control bit 1 reads high");
  unmapped_zero_a: assert property (!mapped |-> SFR_RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  reset_clear_a: assert property ($rose(RESET_N_I) |-> SFR_RDATA_O == RESET_BYTE)
    else $error("register not cleared by reset");
  ctrl_write_a: assert property (s_held_write(is_ctl) |->
    (SFR_RDATA_O & 8'h3d) == ($past(SFR_WDATA_I) & 8'h3d)) else $error("control write lost");
  reload_write_a: assert property (s_held_write(is_rel) |->
    SFR_RDATA_O == $past(SFR_WDATA_I)) else $error("reload write lost");
  flag_sticky_a: assert property ((is_ctl && !SFR_WR_I) ##1 is_ctl |->
    (SFR_RDATA_O[7:6] & $past(SFR_RDATA_O[7:6])) == $past(SFR_RDATA_O[7:6]))
    else $error("flag cleared without write");
  irq_flag_a: assert property ((is_ctl && en_flag && GLOBAL_TIMER_IRQ_ENABLE_I) ##1
    GLOBAL_TIMER_IRQ_ENABLE_I |-> IRQ_O) else $error("enabled flag without interrupt");
  irq_off_a: assert property (!GLOBAL_TIMER_IRQ_ENABLE_I [*2] |-> !IRQ_O)
    else $error("interrupt while disabled");
endmodule // sart_asserts

bind sart_timer sart_asserts i_sart_asserts (.CORE_CLK_I(CORE_CLK_I), .RESET_N_I(RESET_N_I),
  .SFR_ADDR_I(SFR_ADDR_I), .SFR_WDATA_I(SFR_WDATA_I), .SFR_WR_I(SFR_WR_I),
  .SFR_RDATA_O(SFR_RDATA_O), .GLOBAL_TIMER_IRQ_ENABLE_I(GLOBAL_TIMER_IRQ_ENABLE_I),
  .IRQ_O(IRQ_O));

// file: sart_core_model.sv
// processor core model: sfr writes and reads, launched on the falling edge
// assumes the timer takes the bus on the rising edge
`timescale 1ns/1ps
module sart_core_model (
  // bus
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o
);
  initial
  begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
  end
  // strobe spans exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(negedge clk_i);
    wr_o <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    addr_o <= a;
    @(negedge clk_i);
    d = rdata_i;
  endtask
endmodule // sart_core_model

// file: testbench.sv
// self-checking bench for the split auto-reload timer
// assumes the core model owns the sfr bus; bench drives the side inputs
`timescale 1ns/1ps
module testbench;
  import sart_pkg::*;
  logic        clk, rst_n, wr, ext, lfo, sel_lo, sel_hi, gie, irq, q;
  logic [7:0]  addr, wdata, rdata, v;
  logic [7:0]  ctl [3] = '{8'h04, 8'h08, 8'h28};
  logic [15:0] r;
  int          err_total, checks, cyc, k;
  sart_timer i_sart_timer (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .SFR_ADDR_I(addr),
    .SFR_WDATA_I(wdata), .SFR_WR_I(wr), .SFR_RDATA_O(rdata), .EXT_CLK_I(ext),
    .LFO_CLK_I(lfo), .LOW_BYTE_CORE_CLOCK_SELECT_I(sel_lo),
    .HIGH_BYTE_CORE_CLOCK_SELECT_I(sel_hi), .GLOBAL_TIMER_IRQ_ENABLE_I(gie), .IRQ_O(irq));
  sart_core_model i_sart_core_model (.clk_i(clk), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("mismatches %0d comparisons %0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // run k cycles, then a handler pass, then halt: k+6 ticks in all
  task automatic burst(input logic [7:0] c);
    i_sart_core_model.wr(ADDR_CONTROL, c);
    repeat (k) @(negedge clk);
    i_sart_core_model.rd(ADDR_CONTROL, v);
    q = irq;
    i_sart_core_model.wr(ADDR_CONTROL, v & 8'h3f);
    i_sart_core_model.wr(ADDR_CONTROL, 8'h00);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(negedge clk) ext <= 1'($urandom);
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      test_done();
    end
  end
  initial
  begin
    {rst_n, ext, gie, sel_hi} = 4'h0;
    {lfo, sel_lo} = 2'h3;
    void'($urandom(35716));
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      i_sart_core_model.rd(i == 0 ? ADDR_CONTROL : 8'(8'hc9 + i), v);
      chk(v, RESET_BYTE);
    end
    r = 16'($urandom);
    i_sart_core_model.wr(ADDR_CONTROL, r[7:0] & 8'h2b);
    i_sart_core_model.rd(ADDR_CONTROL, v);
    chk(v, r[7:0] & 8'h29);
    i_sart_core_model.wr(ADDR_CONTROL, 8'h00);
    gie = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      r = 16'($urandom) & 16'h7f7f;
      k = $urandom_range(20, 1);
      sel_hi = i != 0;
      i_sart_core_model.wr(ADDR_RELOAD_LOW, r[7:0]);
      i_sart_core_model.wr(ADDR_RELOAD_HIGH, r[15:8]);
      i_sart_core_model.wr(ADDR_COUNT_LOW, BYTE_MAX);
      i_sart_core_model.wr(ADDR_COUNT_HIGH, i == 0 ? BYTE_MAX : 8'h10);
      burst(ctl[i]);
      chk(v, ctl[i] | (i == 0 ? 8'hc0 : 8'h40));
      chk({7'h00, q}, {7'h00, i != 1});
      i_sart_core_model.rd(ADDR_COUNT_LOW, v);
      chk(v, 8'(r[7:0] + k + 5));
      i_sart_core_model.rd(ADDR_COUNT_HIGH, v);
      chk(v, i == 0 ? r[15:8] : 8'h10);
    end
    i_sart_core_model.wr(ADDR_CONTROL, 8'h10);
    lfo <= 1'b0;
    repeat (6) @(negedge clk);
    i_sart_core_model.rd(ADDR_RELOAD_LOW, v);
    chk(v, 8'(r[7:0] + k + 5));
    i_sart_core_model.rd(ADDR_RELOAD_HIGH, v);
    chk(v, 8'h10);
    test_done();
  end
endmodule // testbench
